// ==== pll_cfg_pkg.sv ====
/*
 * constants shared by both ends of the divider programming link:
 * word layout, select codes, reserved-bit masks, reset values, timing.
 * assumes a 25 MHz system clock on both ends.
 */
package pll_cfg_pkg;

    // word and select codes
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_IF_REF = 2'h0;
    localparam logic [1:0] SEL_IF_N = 2'h1;
    localparam logic [1:0] SEL_RF_N = 2'h2;
    localparam logic [1:0] SEL_RF_FRAC = 2'h3;

    // field positions
    localparam int IF_REF_LSB = 2;
    localparam int IF_REF_W = 15;
    localparam int IF_MAIN_LSB = 5;
    localparam int IF_MAIN_W = 12;
    localparam int IF_SWAL_LSB = 2;
    localparam int IF_SWAL_W = 3;
    localparam int IF_GAIN_BIT = 18;
    localparam int RF_MAIN_LSB = 6;
    localparam int RF_MAIN_W = 7;
    localparam int RF_PUMP_LSB = 14;
    localparam int RF_PUMP_W = 4;
    localparam int RF_SWAL_LSB = 20;
    localparam int RF_SWAL_W = 4;
    localparam int FRAC_LSB = 2;
    localparam int FRAC_W = 17;

    // variant: 1 = 16/17 prescaler (4-bit swallow), 0 = 8/9 (top bit ignored)
    localparam logic WIDE_PRESCALER = 1'b1;

    // reserved test bits, forced low by the host
    localparam logic [23:0] TEST_MASK_IF_REF = 24'hfe0000;
    localparam logic [23:0] TEST_MASK_IF_N = 24'h800000;
    localparam logic [23:0] TEST_MASK_RF_N = 24'h000000;
    localparam logic [23:0] TEST_MASK_RF_FRAC = 24'h080000;

    // legal ranges
    localparam int MIN_RATIO = 3;
    localparam int FRAC_LIMIT = 31488;

    // reset values of the latches
    localparam logic [14:0] IF_REF_RST = 15'h0003;
    localparam logic [11:0] IF_MAIN_RST = 12'h003;
    localparam logic [6:0] RF_MAIN_RST = 7'h03;
    localparam logic [3:0] RF_PUMP_RST = 4'h0;

    // pump currents in uA
    localparam logic [9:0] RF_PUMP_STEP_UA = 10'h032;
    localparam logic [9:0] IF_PUMP_LOW_UA = 10'h064;
    localparam logic [9:0] IF_PUMP_HIGH_UA = 10'h320;

    // timing
    localparam int CLK_NS = 40;
    localparam int LINK_CLK_NS = 320;
    localparam int HALF_CYC_RAW = LINK_CLK_NS / (2 * CLK_NS);
    localparam int HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
    localparam int STROBE_NS = 320;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;

    // host register map (byte addresses)
    localparam logic [3:0] ADDR_WORD = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT = 1;

endpackage

// ==== pll_serial_if.sv ====
/*
 * three-wire programming link between host controller and divider block.
 * assumes the host drives all three wires; the device only listens.
 */
`timescale 1ns/1ps
interface pll_serial_if;
    logic sclk;
    logic sdata;
    logic latch_strobe;

    modport host (
        output sclk,
        output sdata,
        output latch_strobe
    );

    modport dev (
        input sclk,
        input sdata,
        input latch_strobe
    );
endinterface // pll_serial_if

// ==== pll_ratio_counter.sv ====
/*
 * programmable down counter that divides a tick stream by a ratio.
 * assumes ticks are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
module pll_ratio_counter #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // tick in, ratio
    input wire logic tick_i,
    input wire logic [W-1:0] ratio_i,
    // terminal count pulse
    output logic tc_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tc;
    } state_s;

    state_s s_q;
    state_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.tc = 1'b0;
        if (tick_i) begin
            if (s_q.cnt <= W'(1)) begin
                // new ratio only taken at terminal count
                s_d.cnt = ratio_i;
                s_d.tc = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tc_o = s_q.tc;
endmodule // pll_ratio_counter

// ==== pll_divider_serial_config.sv ====
/*
 * device end: samples the three-wire link, shifts in 24-bit words,
 * latches them by select code and drives the divider chains.
 * assumes tick inputs are one-cycle pulses on CLK_I, link wires are async.
 */
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// How it works
// - shift 24 bits, msb first, sclk rise
// - strobe rise latches by low select bits
// - host zeroes every reserved test bit
// - serial logic keeps running in power down
// - select 00 loads if reference latch
// - if reference ratio 3..32767, fifteen bits
// - rf reference fixed divide by two
// - selects 01,10,11 load n/fraction latches
// - swallow, main and fraction counter widths
// - if main from bits 16:5, >=3
// - if swallow bits 4:2, below main
// - rf main from bits 12:6, >=3
// - rf swallow bits 23:20, variant width
// - fraction bits 18:2, signed, +-31488
// - if gain bit 18: low/high current
// - rf pump code k gives 50(k+1) uA
module pll_divider_serial_config (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // programming link
    pll_serial_if.dev link,
    // divider tick inputs and power down
    input wire logic REF_TICK_I,
    input wire logic IF_VCO_TICK_I,
    input wire logic RF_VCO_TICK_I,
    input wire logic PWR_DOWN_I,
    // latched settings
    output logic [14:0] IF_REFERENCE_DIVIDER_O,
    output logic [11:0] IF_MAIN_DIVIDER_O,
    output logic [2:0] IF_SWALLOW_COUNT_O,
    output logic [6:0] RF_MAIN_DIVIDER_O,
    output logic [3:0] RF_SWALLOW_COUNT_O,
    output logic [16:0] RF_FRACTIONAL_VALUE_O,
    output logic RF_FRACTION_IN_RANGE_O,
    output logic IF_PUMP_GAIN_SELECT_O,
    output logic [9:0] IF_PUMP_CURRENT_UA_O,
    output logic [3:0] RF_PUMP_CURRENT_CODE_O,
    output logic [9:0] RF_PUMP_CURRENT_UA_O,
    // divider chain outputs
    output logic IF_REF_PULSE_O,
    output logic RF_REF_PULSE_O,
    output logic IF_N_PULSE_O,
    output logic RF_N_PULSE_O,
    output logic IF_MODULUS_O,
    output logic RF_MODULUS_O,
    output logic [16:0] RF_FRACTION_LIVE_O
);
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [1:0] prev;
        logic [23:0] shreg;
        logic [14:0] if_ref;
        logic [11:0] if_main;
        logic [2:0] if_swal;
        logic if_gain;
        logic [9:0] if_ua;
        logic [6:0] rf_main;
        logic [3:0] rf_swal;
        logic [3:0] rf_pump;
        logic [9:0] rf_ua;
        logic [16:0] frac;
        logic frac_ok;
        logic rf_ref_tog;
        logic rf_ref_pulse;
        logic [2:0] if_sw_cnt;
        logic [3:0] rf_sw_cnt;
        logic [16:0] frac_live;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic sclk_s;
    logic sdata_s;
    logic strobe_s;
    logic sclk_rise;
    logic strobe_rise;
    logic ref_tick;
    logic if_tick;
    logic rf_tick;
    logic if_ref_tc;
    logic if_main_tc;
    logic rf_main_tc;

    // second sync stage feeds all logic
    assign sclk_s = s_q.sync2[0];
    assign sdata_s = s_q.sync2[1];
    assign strobe_s = s_q.sync2[2];
    assign sclk_rise = sclk_s & ~s_q.prev[0];
    assign strobe_rise = strobe_s & ~s_q.prev[1];

    // power down stops counting only
    assign ref_tick = REF_TICK_I & ~PWR_DOWN_I;
    assign if_tick = IF_VCO_TICK_I & ~PWR_DOWN_I;
    assign rf_tick = RF_VCO_TICK_I & ~PWR_DOWN_I;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = {link.latch_strobe, link.sdata, link.sclk};
        s_d.sync2 = s_q.sync1;
        s_d.prev = {strobe_s, sclk_s};
        s_d.rf_ref_pulse = 1'b0;

        // shift path never gated by power down
        if (sclk_rise) begin
            s_d.shreg = {s_q.shreg[22:0], sdata_s};
        end

        if (strobe_rise) begin
            case (s_q.shreg[1:0])
                pll_cfg_pkg::SEL_IF_REF: begin
                    s_d.if_ref = s_q.shreg[pll_cfg_pkg::IF_REF_LSB +: pll_cfg_pkg::IF_REF_W];
                end
                pll_cfg_pkg::SEL_IF_N: begin
                    s_d.if_main = s_q.shreg[pll_cfg_pkg::IF_MAIN_LSB +: pll_cfg_pkg::IF_MAIN_W];
                    s_d.if_swal = s_q.shreg[pll_cfg_pkg::IF_SWAL_LSB +: pll_cfg_pkg::IF_SWAL_W];
                    s_d.if_gain = s_q.shreg[pll_cfg_pkg::IF_GAIN_BIT];
                    if (s_q.shreg[pll_cfg_pkg::IF_GAIN_BIT]) begin
                        s_d.if_ua = pll_cfg_pkg::IF_PUMP_HIGH_UA;
                    end else begin
                        s_d.if_ua = pll_cfg_pkg::IF_PUMP_LOW_UA;
                    end
                end
                pll_cfg_pkg::SEL_RF_N: begin
                    s_d.rf_main = s_q.shreg[pll_cfg_pkg::RF_MAIN_LSB +: pll_cfg_pkg::RF_MAIN_W];
                    s_d.rf_pump = s_q.shreg[pll_cfg_pkg::RF_PUMP_LSB +: pll_cfg_pkg::RF_PUMP_W];
                    s_d.rf_ua = 10'(({6'h0, s_q.shreg[pll_cfg_pkg::RF_PUMP_LSB +:
                        pll_cfg_pkg::RF_PUMP_W]} + 10'h001) * pll_cfg_pkg::RF_PUMP_STEP_UA);
                end
                default: begin
                    s_d.rf_swal = s_q.shreg[pll_cfg_pkg::RF_SWAL_LSB +: pll_cfg_pkg::RF_SWAL_W];
                    if (!pll_cfg_pkg::WIDE_PRESCALER) begin
                        s_d.rf_swal[3] = 1'b0;
                    end
                    s_d.frac = s_q.shreg[pll_cfg_pkg::FRAC_LSB +: pll_cfg_pkg::FRAC_W];
                    s_d.frac_ok = ($signed(s_q.shreg[pll_cfg_pkg::FRAC_LSB +: pll_cfg_pkg::FRAC_W])
                        <= 18'sh07b00) && ($signed(s_q.shreg[pll_cfg_pkg::FRAC_LSB +:
                        pll_cfg_pkg::FRAC_W]) >= -18'sh07b00);
                end
            endcase
        end

        // rf reference: every second reference tick
        if (ref_tick) begin
            s_d.rf_ref_tog = ~s_q.rf_ref_tog;
            s_d.rf_ref_pulse = s_q.rf_ref_tog;
        end

        // if swallow phase, reloaded at main terminal count
        if (if_main_tc) begin
            s_d.if_sw_cnt = s_q.if_swal;
        end else if (if_tick && s_q.if_sw_cnt != 3'h0) begin
            s_d.if_sw_cnt = s_q.if_sw_cnt - 3'h1;
        end

        // rf swallow and fraction, reloaded at main terminal count
        if (rf_main_tc) begin
            s_d.rf_sw_cnt = s_q.rf_swal;
            s_d.frac_live = s_q.frac;
        end else if (rf_tick && s_q.rf_sw_cnt != 4'h0) begin
            s_d.rf_sw_cnt = s_q.rf_sw_cnt - 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s_q <= '0;
            s_q.if_ref <= pll_cfg_pkg::IF_REF_RST;
            s_q.if_main <= pll_cfg_pkg::IF_MAIN_RST;
            s_q.rf_main <= pll_cfg_pkg::RF_MAIN_RST;
            s_q.rf_pump <= pll_cfg_pkg::RF_PUMP_RST;
            s_q.if_ua <= pll_cfg_pkg::IF_PUMP_LOW_UA;
            s_q.rf_ua <= pll_cfg_pkg::RF_PUMP_STEP_UA;
            s_q.frac_ok <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // divider chains
    pll_ratio_counter #(.W(pll_cfg_pkg::IF_REF_W)) if_ref_div (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .tick_i(ref_tick),
        .ratio_i(s_q.if_ref),
        .tc_o(if_ref_tc)
    );

    pll_ratio_counter #(.W(pll_cfg_pkg::IF_MAIN_W)) if_main_div (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .tick_i(if_tick),
        .ratio_i(s_q.if_main),
        .tc_o(if_main_tc)
    );

    pll_ratio_counter #(.W(pll_cfg_pkg::RF_MAIN_W)) rf_main_div (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .tick_i(rf_tick),
        .ratio_i(s_q.rf_main),
        .tc_o(rf_main_tc)
    );

    // outputs
    assign IF_REFERENCE_DIVIDER_O = s_q.if_ref;
    assign IF_MAIN_DIVIDER_O = s_q.if_main;
    assign IF_SWALLOW_COUNT_O = s_q.if_swal;
    assign RF_MAIN_DIVIDER_O = s_q.rf_main;
    assign RF_SWALLOW_COUNT_O = s_q.rf_swal;
    assign RF_FRACTIONAL_VALUE_O = s_q.frac;
    assign RF_FRACTION_IN_RANGE_O = s_q.frac_ok;
    assign IF_PUMP_GAIN_SELECT_O = s_q.if_gain;
    assign IF_PUMP_CURRENT_UA_O = s_q.if_ua;
    assign RF_PUMP_CURRENT_CODE_O = s_q.rf_pump;
    assign RF_PUMP_CURRENT_UA_O = s_q.rf_ua;
    assign IF_REF_PULSE_O = if_ref_tc;
    assign RF_REF_PULSE_O = s_q.rf_ref_pulse;
    assign IF_N_PULSE_O = if_main_tc;
    assign RF_N_PULSE_O = rf_main_tc;
    assign IF_MODULUS_O = s_q.if_sw_cnt != 3'h0;
    assign RF_MODULUS_O = s_q.rf_sw_cnt != 4'h0;
    assign RF_FRACTION_LIVE_O = s_q.frac_live;
endmodule // pll_divider_serial_config

// ==== pll_serial_host.sv ====
/*
 * host end: Avalon-MM slave registers; on go, checks the word, clears
 * reserved bits and sends it msb first, then pulses the latch strobe.
 * assumes the device samples the link with its own clock.
 */
`timescale 1ns/1ps
module pll_serial_host (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // avalon-mm slave
    input wire logic [3:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic [31:0] WRITEDATA_I,
    output logic [31:0] READDATA_O,
    output logic WAITREQUEST_O,
    // programming link
    pll_serial_if.host link
);
    typedef enum {ST_IDLE, ST_SHIFT, ST_LATCH} state_e;

    typedef struct packed {
        state_e st;
        logic [23:0] word;
        logic [23:0] shreg;
        logic [4:0] bitn;
        logic [3:0] ph;
        logic sclk;
        logic sdata;
        logic strobe;
        logic err;
        logic [6:0] rf_main;
        logic rd_valid;
        logic [31:0] rdata;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic busy;
    logic legal;
    logic [23:0] masked;

    assign busy = s_q.st != ST_IDLE;

    // range checks on the stored word
    always_comb begin
        legal = 1'b1;
        masked = s_q.word;
        case (s_q.word[1:0])
            pll_cfg_pkg::SEL_IF_REF: begin
                masked = s_q.word & ~pll_cfg_pkg::TEST_MASK_IF_REF;
                legal = s_q.word[16:2] >= 15'(pll_cfg_pkg::MIN_RATIO);
            end
            pll_cfg_pkg::SEL_IF_N: begin
                masked = s_q.word & ~pll_cfg_pkg::TEST_MASK_IF_N;
                legal = (s_q.word[16:5] >= 12'(pll_cfg_pkg::MIN_RATIO))
                    && ({9'h0, s_q.word[4:2]} < s_q.word[16:5]);
            end
            pll_cfg_pkg::SEL_RF_N: begin
                masked = s_q.word & ~pll_cfg_pkg::TEST_MASK_RF_N;
                legal = s_q.word[12:6] >= 7'(pll_cfg_pkg::MIN_RATIO);
            end
            default: begin
                masked = s_q.word & ~pll_cfg_pkg::TEST_MASK_RF_FRAC;
                legal = ({3'h0, s_q.word[23:20]} < s_q.rf_main)
                    && ($signed(s_q.word[18:2]) <= 18'sh07b00)
                    && ($signed(s_q.word[18:2]) >= -18'sh07b00);
            end
        endcase
    end

    // writes stall while a word is in flight; reads take one wait cycle
    assign WAITREQUEST_O = (WRITE_I && busy) || (READ_I && !s_q.rd_valid);

    always_comb begin
        s_d = s_q;
        s_d.rd_valid = READ_I && !s_q.rd_valid;
        if (READ_I && !s_q.rd_valid) begin
            if (ADDRESS_I == pll_cfg_pkg::ADDR_WORD) begin
                s_d.rdata = {8'h00, s_q.word};
            end else if (ADDRESS_I == pll_cfg_pkg::ADDR_STATUS) begin
                s_d.rdata = 32'h0;
                s_d.rdata[pll_cfg_pkg::STAT_BUSY_BIT] = busy;
                s_d.rdata[pll_cfg_pkg::STAT_ERR_BIT] = s_q.err;
            end else begin
                s_d.rdata = 32'h0;
            end
        end
        case (s_q.st)
            ST_IDLE: begin
                if (WRITE_I && ADDRESS_I == pll_cfg_pkg::ADDR_WORD) begin
                    s_d.word = WRITEDATA_I[23:0];
                end else if (WRITE_I && ADDRESS_I == pll_cfg_pkg::ADDR_CTRL
                        && WRITEDATA_I[pll_cfg_pkg::CTRL_GO_BIT]) begin
                    s_d.err = !legal;
                    if (legal) begin
                        s_d.st = ST_SHIFT;
                        s_d.shreg = masked;
                        s_d.sdata = masked[23];
                        s_d.bitn = 5'h17;
                        s_d.ph = 4'h0;
                        if (s_q.word[1:0] == pll_cfg_pkg::SEL_RF_N) begin
                            s_d.rf_main = s_q.word[12:6];
                        end
                    end
                end
            end
            ST_SHIFT: begin
                s_d.ph = s_q.ph + 4'h1;
                if (s_q.ph == 4'(pll_cfg_pkg::HALF_CYC - 1)) begin
                    s_d.sclk = 1'b1;
                end
                if (s_q.ph == 4'(2 * pll_cfg_pkg::HALF_CYC - 1)) begin
                    s_d.sclk = 1'b0;
                    s_d.ph = 4'h0;
                    if (s_q.bitn == 5'h00) begin
                        s_d.st = ST_LATCH;
                        s_d.strobe = 1'b1;
                    end else begin
                        s_d.bitn = s_q.bitn - 5'h01;
                        s_d.shreg = {s_q.shreg[22:0], 1'b0};
                        s_d.sdata = s_q.shreg[22];
                    end
                end
            end
            default: begin
                s_d.ph = s_q.ph + 4'h1;
                if (s_q.ph == 4'(pll_cfg_pkg::STROBE_CYC - 1)) begin
                    s_d.strobe = 1'b0;
                    s_d.sdata = 1'b0;
                    s_d.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.rf_main <= pll_cfg_pkg::RF_MAIN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign READDATA_O = s_q.rdata;
    assign link.sclk = s_q.sclk;
    assign link.sdata = s_q.sdata;
    assign link.latch_strobe = s_q.strobe;
endmodule // pll_serial_host

// ==== pll_link_asserts.sv ====
/*
 * link checker: timing and content of the three-wire programming link.
 * assumes the host end drives every wire from registers on CLK_I.
 */
`timescale 1ns/1ps
module pll_link_checker (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic [23:0] word_q;
    logic [5:0] bits_q;
    logic [23:0] mask;

    // shadow shift register and bit count since last strobe
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            word_q <= 24'h000000;
            bits_q <= 6'h00;
        end else if ($rose(latch_strobe)) begin
            bits_q <= 6'h00;
        end else if ($rose(sclk)) begin
            word_q <= {word_q[22:0], sdata};
            bits_q <= bits_q + 6'h01;
        end
    end

    always_comb begin
        case (word_q[1:0])
            pll_cfg_pkg::SEL_IF_REF: mask = pll_cfg_pkg::TEST_MASK_IF_REF;
            pll_cfg_pkg::SEL_IF_N: mask = pll_cfg_pkg::TEST_MASK_IF_N;
            pll_cfg_pkg::SEL_RF_N: mask = pll_cfg_pkg::TEST_MASK_RF_N;
            default: mask = pll_cfg_pkg::TEST_MASK_RF_FRAC;
        endcase
    end

    sequence strobe_pulse_s;
        latch_strobe [*8] ##1 !latch_strobe;
    endsequence
    sequence sclk_high_s;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence sclk_low_s;
        !sclk [*4];
    endsequence

    strobe_len_a: assert property ($rose(latch_strobe) |-> strobe_pulse_s)
        else $error("latch strobe length wrong");
    sclk_quiet_a: assert property (latch_strobe |-> !sclk)
        else $error("serial clock high during strobe");
    sclk_high_a: assert property ($rose(sclk) |-> sclk_high_s)
        else $error("serial clock high phase wrong");
    sclk_low_a: assert property ($fell(sclk) |-> sclk_low_s)
        else $error("serial clock low phase too short");
    data_hold_a: assert property (sclk |-> $stable(sdata))
        else $error("data moved while serial clock high");
    bit_count_a: assert property ($rose(latch_strobe) |-> bits_q == 6'h18)
        else $error("strobe not after 24 bits");
    strobe_follow_a: assert property (($fell(sclk) && bits_q == 6'h18)
        |-> $rose(latch_strobe))
        else $error("no strobe after full word");
    test_zero_a: assert property ($rose(latch_strobe) |-> (word_q & mask) == 24'h000000)
        else $error("reserved bit set in word");
endmodule // pll_link_checker

// ==== tb_pll_divider_serial_config.sv ====
/*
 * testbench: host end and device end joined by the link; avalon stimulus,
 * queued expectations checked when each latch strobe lands.
 * assumes 25 MHz clock and the host register map of the package.
 */
`timescale 1ns/1ps
module tb_pll_divider_serial_config;
    logic CLK_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    logic [3:0] ADDRESS_I = 4'h0;
    logic READ_I = 1'b0;
    logic WRITE_I = 1'b0;
    logic [31:0] WRITEDATA_I = 32'h00000000;
    logic [31:0] READDATA_O;
    logic WAITREQUEST_O;
    logic REF_TICK_I = 1'b0;
    logic IF_VCO_TICK_I = 1'b0;
    logic RF_VCO_TICK_I = 1'b0;
    logic PWR_DOWN_I = 1'b0;
    logic tick_en = 1'b0;
    logic [14:0] if_ref;
    logic [11:0] if_main;
    logic [2:0] if_swal;
    logic [6:0] rf_main;
    logic [3:0] rf_swal, rf_code;
    logic [16:0] rf_frac;
    logic [9:0] if_ua, rf_ua;
    logic frac_ok, if_gain, if_rp, rf_rp, if_np, rf_np;
    int num_errors = 0;
    int check_count = 0;
    int rf_main_last = 3;
    int cnt;
    logic [31:0] rd_q;
    logic [23:0] mon_w;
    logic [23:0] notes [$];
    logic [23:0] sh [4] = '{24'h00000c, 24'h000061, 24'h0000c2, 24'h000003};
    logic [23:0] edge_w [8] = '{24'h00000c, 24'h01fffc, 24'h000069, 24'h05fffd,
                               24'h0000c2, 24'h03dfc2, 24'h061403, 24'hf1ec03};
    logic [23:0] bad_w [5] = '{24'h000008, 24'h000041, 24'h00006d, 24'h000082, 24'h01ec07};

    pll_serial_if link ();
    pll_serial_host i_pll_serial_host (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
        .ADDRESS_I(ADDRESS_I), .READ_I(READ_I), .WRITE_I(WRITE_I),
        .WRITEDATA_I(WRITEDATA_I), .READDATA_O(READDATA_O),
        .WAITREQUEST_O(WAITREQUEST_O), .link(link));
    pll_divider_serial_config i_pll_divider_serial_config (.CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I), .link(link), .REF_TICK_I(REF_TICK_I),
        .IF_VCO_TICK_I(IF_VCO_TICK_I), .RF_VCO_TICK_I(RF_VCO_TICK_I),
        .PWR_DOWN_I(PWR_DOWN_I), .IF_REFERENCE_DIVIDER_O(if_ref),
        .IF_MAIN_DIVIDER_O(if_main), .IF_SWALLOW_COUNT_O(if_swal),
        .RF_MAIN_DIVIDER_O(rf_main), .RF_SWALLOW_COUNT_O(rf_swal),
        .RF_FRACTIONAL_VALUE_O(rf_frac), .RF_FRACTION_IN_RANGE_O(frac_ok),
        .IF_PUMP_GAIN_SELECT_O(if_gain), .IF_PUMP_CURRENT_UA_O(if_ua),
        .RF_PUMP_CURRENT_CODE_O(rf_code), .RF_PUMP_CURRENT_UA_O(rf_ua),
        .IF_REF_PULSE_O(if_rp), .RF_REF_PULSE_O(rf_rp), .IF_N_PULSE_O(if_np),
        .RF_N_PULSE_O(rf_np), .IF_MODULUS_O(), .RF_MODULUS_O(), .RF_FRACTION_LIVE_O());
    pll_link_checker i_pll_link_checker (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
        .sclk(link.sclk), .sdata(link.sdata), .latch_strobe(link.latch_strobe));

    always #20 CLK_I = ~CLK_I;

    always @(posedge CLK_I) begin
        REF_TICK_I <= tick_en & ~REF_TICK_I;
        IF_VCO_TICK_I <= 1'($urandom % 2);
        RF_VCO_TICK_I <= 1'($urandom % 2);
    end

    task results();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, entered just after a rising edge
    task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        ADDRESS_I <= a;
        WRITEDATA_I <= d;
        WRITE_I <= w;
        READ_I <= !w;
        n = 0;
        do begin
            @(negedge CLK_I);
            n++;
        end while (WAITREQUEST_O !== 1'b0 && n < 1000);
        @(posedge CLK_I);
        q = READDATA_O;
        WRITE_I <= 1'b0;
        READ_I <= 1'b0;
        @(posedge CLK_I);
        if (n >= 1000) begin
            num_errors++;
            results();
        end
    endtask

    task send(input logic [23:0] w, input logic ok);
        logic [31:0] q;
        av(1'b1, pll_cfg_pkg::ADDR_WORD, {8'ha5, w}, q);
        av(1'b1, pll_cfg_pkg::ADDR_CTRL, 32'h00000001, q);
        if (ok) notes.push_back(w);
        if (ok && w[1:0] == pll_cfg_pkg::SEL_RF_N) rf_main_last = w[12:6];
        av(1'b0, pll_cfg_pkg::ADDR_STATUS, 32'h00000000, q);
        check(q[1:0], ok ? 2'h1 : 2'h2);
    endtask

    task idle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            av(1'b0, pll_cfg_pkg::ADDR_STATUS, 32'h00000000, q);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        if (n >= 500) begin
            num_errors++;
            results();
        end
    endtask

    // cycles between the last two reference pulses of three
    task gap(input logic rf, output int g);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge CLK_I);
                n++;
            end while ((rf ? rf_rp : if_rp) !== 1'b1 && n < 200);
        end
        g = n;
        @(posedge CLK_I);
        if (n >= 200) begin
            num_errors++;
            results();
        end
    endtask

    function automatic logic [23:0] mk(input int s);
        logic [23:0] w;
        int m;
        w = 24'($urandom);
        case (s)
            0: w[16:2] = 15'(3 + $urandom % 32765);
            1: begin
                m = 3 + $urandom % 4093;
                w[16:5] = 12'(m);
                w[4:2] = 3'($urandom % (m < 8 ? m : 8));
            end
            2: w[12:6] = 7'(3 + $urandom % 125);
            default: begin
                w[23:20] = 4'($urandom % (rf_main_last < 16 ? rf_main_last : 16));
                w[18:2] = 17'($urandom % 62977 - 31488);
            end
        endcase
        w[1:0] = 2'(s);
        return w;
    endfunction

    task cmp_all();
        check(if_ref, sh[0][16:2]);
        check(if_main, sh[1][16:5]);
        check(if_swal, sh[1][4:2]);
        check(if_gain, sh[1][18]);
        check(if_ua, sh[1][18] ? pll_cfg_pkg::IF_PUMP_HIGH_UA : pll_cfg_pkg::IF_PUMP_LOW_UA);
        check(rf_main, sh[2][12:6]);
        check(rf_code, sh[2][17:14]);
        check(rf_ua, 10'h032 * (sh[2][17:14] + 1));
        check(rf_swal, sh[3][23:20]);
        check(rf_frac, sh[3][18:2]);
        check(frac_ok, 1'b1);
    endtask

    // watcher: each strobe retires the oldest note
    initial begin
        forever begin
            @(posedge link.latch_strobe);
            repeat (8) @(posedge CLK_I);
            @(negedge CLK_I);
            if (notes.size() == 0) check(1, 0);
            else begin
                mon_w = notes.pop_front();
                sh[mon_w[1:0]] = mon_w;
                cmp_all();
            end
        end
    end

    initial begin
        void'($urandom(32'h66fa4d68));
        repeat (6) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        repeat (4) @(posedge CLK_I);
        @(negedge CLK_I);
        cmp_all();
        @(posedge CLK_I);
        av(1'b1, 4'hc, 32'hffffffff, rd_q);
        av(1'b0, 4'hc, 32'h00000000, rd_q);
        check(rd_q, 32'h00000000);
        foreach (edge_w[i]) send(edge_w[i], 1'b1);
        foreach (bad_w[i]) send(bad_w[i], 1'b0);
        for (int r = 0; r < 3; r++) begin
            for (int s = 0; s < 4; s++) send(mk(s), 1'b1);
        end
        PWR_DOWN_I <= 1'b1;
        tick_en <= 1'b1;
        send(24'h000014, 1'b1);
        idle();
        cnt = 0;
        repeat (40) begin
            @(negedge CLK_I);
            if (if_rp === 1'b1 || rf_rp === 1'b1 || (if_np | rf_np) === 1'b1) cnt++;
        end
        check(cnt, 0);
        @(posedge CLK_I);
        PWR_DOWN_I <= 1'b0;
        gap(1'b0, cnt);
        check(cnt, 10);
        gap(1'b1, cnt);
        check(cnt, 4);
        send(24'h00000c, 1'b1);
        idle();
        gap(1'b0, cnt);
        check(cnt, 6);
        repeat (12) @(posedge CLK_I);
        check(notes.size(), 0);
        results();
    end
endmodule // tb_pll_divider_serial_config
